/* File: core/rtcfg_params.svh */
// constants for the rt configuration upper-field block
`ifndef RTCFG_PARAMS_SVH
`define RTCFG_PARAMS_SVH
`define RTCFG_REG_ADDR 16'h0017
`define RTCFG_TO_MSB 15
`define RTCFG_TO_LSB 14
`define RTCFG_INHA_BIT 13
`define RTCFG_INHB_BIT 12
`define RTCFG_RESET_VAL 4'h0
`define RTCFG_CLK_PERIOD_PS 4000
`define RTCFG_PS_PER_US 1000000
`define RTCFG_TO_00_US 57
`define RTCFG_TO_01_US 62
`define RTCFG_TO_10_US 100
`define RTCFG_TO_11_US 180
`define RTCFG_DEAD_00_US 8'h0f
`define RTCFG_DEAD_01_US 8'h14
`define RTCFG_DEAD_10_US 8'h3a
`define RTCFG_DEAD_11_US 8'h8a
`define RTCFG_EMBED_WORD_US 20
`endif

/* File: core/rtcfg_pkg.sv */
// types for the rt configuration upper-field block
package rtcfg_pkg;
    typedef struct packed {
        logic [1:0] rt_to_rt_timeout_select;
        logic bus_a_local_inhibit;
        logic bus_b_local_inhibit;
    } rtcfg_fields_t;

    typedef struct packed {
        logic tx_inhibit;
        logic rx_inhibit;
    } rtcfg_bus_inh_t;

    typedef enum logic [0:0] {
        RTCFG_IDLE = 1'b0,
        RTCFG_WAIT = 1'b1
    } rtcfg_state_t;
endpackage

/* File: core/rtcfg_top.sv */
// rt configuration register upper field: rt-rt timeout timer and per-bus inhibits
`timescale 1ns/1ps
`include "rtcfg_params.svh"

// Functional notes
// - select picks 57/62/100/180us limit, dead time
// - time from command parity to data sync
// - limit spans embedded transmit command and status
// - bus A inhibit bit inhibits per scope
// - scope option: both directions or transmit only
// - bus A transmit also inhibited by pin, master bit; receive is not
// - bus B inhibit bit inhibits per scope
// - bus B transmit also inhibited by pin, master bit; receive is not
// - pointer auto-increments per word under select
module rtcfg_top #(
    parameter int unsigned TO_00_CYC = `RTCFG_TO_00_US * `RTCFG_PS_PER_US / `RTCFG_CLK_PERIOD_PS,
    parameter int unsigned TO_01_CYC = `RTCFG_TO_01_US * `RTCFG_PS_PER_US / `RTCFG_CLK_PERIOD_PS,
    parameter int unsigned TO_10_CYC = `RTCFG_TO_10_US * `RTCFG_PS_PER_US / `RTCFG_CLK_PERIOD_PS,
    parameter int unsigned TO_11_CYC = `RTCFG_TO_11_US * `RTCFG_PS_PER_US / `RTCFG_CLK_PERIOD_PS,
    parameter int unsigned CNT_W = 16
) (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic cs_n_in,
    input wire logic map_load_in,
    input wire logic [15:0] map_value_in,
    input wire logic word_wr_in,
    input wire logic word_rd_in,
    input wire logic [15:0] word_wdata_in,
    output logic [15:0] word_rdata_out,
    output logic [15:0] map_out,
    input wire logic inhibit_scope_option_in,
    input wire logic bus_a_tx_inhibit_pin_in,
    input wire logic bus_b_tx_inhibit_pin_in,
    input wire logic master_inhibit_in,
    input wire logic rx_cmd_parity_mid_in,
    input wire logic data_sync_mid_in,
    output rtcfg_pkg::rtcfg_fields_t fields_out,
    output rtcfg_pkg::rtcfg_bus_inh_t bus_a_inh_out,
    output rtcfg_pkg::rtcfg_bus_inh_t bus_b_inh_out,
    output logic [7:0] dead_time_us_out,
    output logic timer_busy_out,
    output logic no_response_out
);
    import rtcfg_pkg::*;

    // every limit must fit the counter; short limits only suit quick simulation
    if (CNT_W < 2 || CNT_W > 31 || TO_00_CYC < 2 || TO_01_CYC < 2 || TO_10_CYC < 2
        || TO_11_CYC < 2 || TO_11_CYC >= (32'h1 << CNT_W)
        || TO_10_CYC >= (32'h1 << CNT_W) || TO_01_CYC >= (32'h1 << CNT_W)
        || TO_00_CYC >= (32'h1 << CNT_W)) begin : g_bad_cfg
        $error("rtcfg_top: timeout counts do not fit the counter");
    end

    // ****************************************
    // memory address pointer and register access
    // ****************************************
    logic [15:0] map_ff;
    rtcfg_fields_t cfg_ff;
    logic [15:0] rdata_ff;
    logic hit;
    logic access;

    assign hit = (map_ff == `RTCFG_REG_ADDR);
    assign access = !cs_n_in && (word_wr_in || word_rd_in);
    assign map_out = map_ff;
    assign word_rdata_out = rdata_ff;
    assign fields_out = cfg_ff;

    // pointer steps after each word while select is held
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            map_ff <= 16'h0000;
        end else if (map_load_in) begin
            map_ff <= map_value_in;
        end else if (access) begin
            map_ff <= map_ff + 16'h0001;
        end
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            cfg_ff <= `RTCFG_RESET_VAL;
        end else if (!map_load_in && !cs_n_in && word_wr_in && hit) begin
            cfg_ff.rt_to_rt_timeout_select <= word_wdata_in[`RTCFG_TO_MSB:`RTCFG_TO_LSB];
            cfg_ff.bus_a_local_inhibit <= word_wdata_in[`RTCFG_INHA_BIT];
            cfg_ff.bus_b_local_inhibit <= word_wdata_in[`RTCFG_INHB_BIT];
        end
    end

    // lower bits belong to another block and read as zero here
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_ff <= 16'h0000;
        end else if (!map_load_in && !cs_n_in && word_rd_in) begin
            rdata_ff <= hit ? {cfg_ff, 12'h000} : 16'h0000;
        end
    end

    // ****************************************
    // bus inhibits
    // ****************************************
    // scope option high blocks both directions; low blocks transmit only
    always_comb begin
        bus_a_inh_out.tx_inhibit = cfg_ff.bus_a_local_inhibit
            || bus_a_tx_inhibit_pin_in || master_inhibit_in;
        bus_a_inh_out.rx_inhibit = cfg_ff.bus_a_local_inhibit && inhibit_scope_option_in;
        bus_b_inh_out.tx_inhibit = cfg_ff.bus_b_local_inhibit
            || bus_b_tx_inhibit_pin_in || master_inhibit_in;
        bus_b_inh_out.rx_inhibit = cfg_ff.bus_b_local_inhibit && inhibit_scope_option_in;
    end

    // ****************************************
    // rt-rt no-response timer
    // ****************************************
    logic [CNT_W-1:0] lim_cyc;
    logic [CNT_W-1:0] cnt_ff;
    rtcfg_state_t state_ff;
    logic no_resp_ff;
    logic expire;

    always_comb begin
        case (cfg_ff.rt_to_rt_timeout_select)
            2'b00: begin
                lim_cyc = CNT_W'(TO_00_CYC);
                dead_time_us_out = `RTCFG_DEAD_00_US;
            end
            2'b01: begin
                lim_cyc = CNT_W'(TO_01_CYC);
                dead_time_us_out = `RTCFG_DEAD_01_US;
            end
            2'b10: begin
                lim_cyc = CNT_W'(TO_10_CYC);
                dead_time_us_out = `RTCFG_DEAD_10_US;
            end
            default: begin
                lim_cyc = CNT_W'(TO_11_CYC);
                dead_time_us_out = `RTCFG_DEAD_11_US;
            end
        endcase
    end

    // the limit already includes the 40us of transmit command and status words
    assign expire = (state_ff == RTCFG_WAIT) && !data_sync_mid_in
        && (cnt_ff >= lim_cyc - CNT_W'(1));
    assign timer_busy_out = (state_ff == RTCFG_WAIT);
    assign no_response_out = no_resp_ff;

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_ff <= RTCFG_IDLE;
            cnt_ff <= '0;
        end else if (rx_cmd_parity_mid_in) begin
            state_ff <= RTCFG_WAIT;
            cnt_ff <= '0;
        end else begin
            case (state_ff)
                RTCFG_IDLE: begin
                    cnt_ff <= '0;
                end
                RTCFG_WAIT: begin
                    if (data_sync_mid_in || expire) begin
                        state_ff <= RTCFG_IDLE;
                    end
                    cnt_ff <= cnt_ff + CNT_W'(1);
                end
                default: begin
                    state_ff <= RTCFG_IDLE;
                end
            endcase
        end
    end

    // flag holds until the next rt-rt message starts timing
    // an expiry in the very cycle of a new start still gets reported
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            no_resp_ff <= 1'b0;
        end else if (expire) begin
            no_resp_ff <= 1'b1;
        end else if (rx_cmd_parity_mid_in) begin
            no_resp_ff <= 1'b0;
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    property p_limit_sel;
        @(posedge sys_clk_in) disable iff (rst_in)
        (cfg_ff.rt_to_rt_timeout_select == 2'b10) |-> (lim_cyc == CNT_W'(TO_10_CYC));
    endproperty
    a_limit_sel: assert property (p_limit_sel) else $error("limit select wrong");

    property p_start;
        @(posedge sys_clk_in) disable iff (rst_in)
        (rx_cmd_parity_mid_in && !expire)
            |=> (timer_busy_out && cnt_ff == '0 && !no_response_out);
    endproperty
    a_start: assert property (p_start) else $error("timer did not start");

    property p_start_expire;
        @(posedge sys_clk_in) disable iff (rst_in)
        (rx_cmd_parity_mid_in && expire)
            |=> (timer_busy_out && cnt_ff == '0 && no_response_out);
    endproperty
    a_start_expire: assert property (p_start_expire) else $error("expiry lost on restart");

    property p_sync_stop;
        @(posedge sys_clk_in) disable iff (rst_in)
        (timer_busy_out && data_sync_mid_in && !rx_cmd_parity_mid_in)
            |=> (!timer_busy_out && !no_response_out);
    endproperty
    a_sync_stop: assert property (p_sync_stop) else $error("sync did not stop timer");

    property p_fire_late;
        @(posedge sys_clk_in) disable iff (rst_in)
        $rose(no_response_out) |-> ($past(cnt_ff) == lim_cyc - CNT_W'(1));
    endproperty
    a_fire_late: assert property (p_fire_late) else $error("no-response at wrong count");

    property p_inh_a;
        @(posedge sys_clk_in) disable iff (rst_in)
        cfg_ff.bus_a_local_inhibit |-> (bus_a_inh_out.tx_inhibit
            && bus_a_inh_out.rx_inhibit == inhibit_scope_option_in);
    endproperty
    a_inh_a: assert property (p_inh_a) else $error("bus a local inhibit lost");

    property p_glob_a;
        @(posedge sys_clk_in) disable iff (rst_in)
        !cfg_ff.bus_a_local_inhibit |-> (!bus_a_inh_out.rx_inhibit
            && bus_a_inh_out.tx_inhibit == (bus_a_tx_inhibit_pin_in || master_inhibit_in));
    endproperty
    a_glob_a: assert property (p_glob_a) else $error("bus a global inhibit wrong");

    property p_inh_b;
        @(posedge sys_clk_in) disable iff (rst_in)
        cfg_ff.bus_b_local_inhibit |-> (bus_b_inh_out.tx_inhibit
            && bus_b_inh_out.rx_inhibit == inhibit_scope_option_in);
    endproperty
    a_inh_b: assert property (p_inh_b) else $error("bus b local inhibit lost");

    property p_glob_b;
        @(posedge sys_clk_in) disable iff (rst_in)
        !cfg_ff.bus_b_local_inhibit |-> (!bus_b_inh_out.rx_inhibit
            && bus_b_inh_out.tx_inhibit == (bus_b_tx_inhibit_pin_in || master_inhibit_in));
    endproperty
    a_glob_b: assert property (p_glob_b) else $error("bus b global inhibit wrong");

    property p_map_step;
        @(posedge sys_clk_in) disable iff (rst_in)
        (access && !map_load_in) |=> (map_ff == $past(map_ff) + 16'h0001);
    endproperty
    a_map_step: assert property (p_map_step) else $error("pointer did not step");

    property p_wr_read;
        @(posedge sys_clk_in) disable iff (rst_in)
        (!cs_n_in && word_wr_in && !map_load_in && hit)
            |=> (fields_out == $past(word_wdata_in[15:12]));
    endproperty
    a_wr_read: assert property (p_wr_read) else $error("register write lost");

    property p_sticky;
        @(posedge sys_clk_in) disable iff (rst_in)
        (no_response_out && !rx_cmd_parity_mid_in) |=> no_response_out;
    endproperty
    a_sticky: assert property (p_sticky) else $error("no-response dropped");

    c_timeout: cover property (@(posedge sys_clk_in) disable iff (rst_in) $rose(no_response_out));
    c_sync: cover property (@(posedge sys_clk_in) disable iff (rst_in)
        timer_busy_out && data_sync_mid_in);
    c_write: cover property (@(posedge sys_clk_in) disable iff (rst_in)
        !cs_n_in && word_wr_in && hit);
endmodule

/* File: tb/rtcfg_bus_model.sv */
// far-side bus model: rt-rt receive command parity and first data sync
`timescale 1ns/1ps
// ****************
// bus pulse source
// ****************
module rtcfg_bus_model (
    input wire logic clk_in,
    input wire logic go_in,
    input wire logic [15:0] gap_in,
    output logic parity_mid_out,
    output logic sync_mid_out
);
    logic [15:0] cnt_ff;
    initial begin
        parity_mid_out = 1'b0;
        sync_mid_out = 1'b0;
        cnt_ff = 16'h0000;
    end
    // gap of zero models a transmitter that never answers
    always @(negedge clk_in) begin
        parity_mid_out <= go_in;
        sync_mid_out <= (cnt_ff == 16'h0001);
        if (go_in) begin
            cnt_ff <= gap_in;
        end else if (cnt_ff != 16'h0000) begin
            cnt_ff <= cnt_ff - 16'h0001;
        end
    end
endmodule

/* File: tb/testbench.sv */
// self-checking bench for the rt configuration upper-field block
`timescale 1ns/1ps
module testbench;
    import rtcfg_pkg::*;
    // ****************
    // signals
    // ****************
    logic clk = 1'b0, rst, cs_n, mload, wr, rd, scope, pa, pb, mst, go, par, syn;
    logic busy, nresp;
    logic [15:0] mval, wdata, rdata, map, gap_v, d;
    logic [31:0] seed = 32'h98ff, r;
    logic [3:0] mf;
    logic [7:0] dead;
    rtcfg_fields_t fields;
    rtcfg_bus_inh_t inh_a, inh_b;
    int error_cnt = 0, total_checks = 0;
    int lim[4] = '{50, 60, 70, 80};
    int dt[4] = '{15, 20, 58, 138};
    always #2 clk = ~clk;
    rtcfg_top #(.TO_00_CYC(50), .TO_01_CYC(60), .TO_10_CYC(70), .TO_11_CYC(80)) i_rtcfg_top (
        .sys_clk_in(clk), .rst_in(rst), .cs_n_in(cs_n), .map_load_in(mload),
        .map_value_in(mval), .word_wr_in(wr), .word_rd_in(rd), .word_wdata_in(wdata),
        .word_rdata_out(rdata), .map_out(map), .inhibit_scope_option_in(scope),
        .bus_a_tx_inhibit_pin_in(pa), .bus_b_tx_inhibit_pin_in(pb), .master_inhibit_in(mst),
        .rx_cmd_parity_mid_in(par), .data_sync_mid_in(syn), .fields_out(fields),
        .bus_a_inh_out(inh_a), .bus_b_inh_out(inh_b), .dead_time_us_out(dead),
        .timer_busy_out(busy), .no_response_out(nresp));
    rtcfg_bus_model i_rtcfg_bus_model (.clk_in(clk), .go_in(go), .gap_in(gap_v),
        .parity_mid_out(par), .sync_mid_out(syn));
    // ****************
    // helpers
    // ****************
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic load_map(input logic [15:0] a);
        @(negedge clk);
        mload <= 1'b1;
        mval <= a;
        @(negedge clk);
        mload <= 1'b0;
    endtask
    task automatic acc(input logic w, input logic c, input logic [15:0] v);
        @(negedge clk);
        cs_n <= c;
        wr <= w;
        rd <= ~w;
        wdata <= v;
        @(negedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        cs_n <= 1'b1;
    endtask
    task automatic run_timer(input int gap, input int l);
        int n;
        n = 0;
        gap_v <= 16'(gap);
        go <= 1'b1;
        @(negedge clk);
        go <= 1'b0;
        do @(posedge clk); while (par !== 1'b1);
        @(negedge clk);
        while (busy === 1'b1 && n < 1000) begin
            n++;
            @(negedge clk);
        end
        check(16'(n), 16'((gap == 0 || gap > l) ? l : gap));
        check(16'(nresp), 16'(gap == 0 || gap > l));
    endtask
    // ****************
    // sequence
    // ****************
    initial begin
        #200000;
        error_cnt++;
        test_done();
    end
    initial begin
        {rst, cs_n, mload, wr, rd, scope, pa, pb, mst, go} = 10'h300;
        {mval, wdata, gap_v} = '0;
        repeat (10) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        check({12'h000, fields}, 16'h0000);
        check({8'h00, dead}, 16'h000f);
        check(map, 16'h0000);
        check({15'h0000, nresp}, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            r = rnd();
            d = {i[1:0], r[13:0]};
            mf = d[15:12];
            load_map(16'h0017);
            acc(1'b1, 1'b0, d);
            check({12'h000, fields}, {12'h000, mf});
            check(map, 16'h0018);
            acc(1'b1, 1'b0, ~d);
            check({12'h000, fields}, {12'h000, mf});
            load_map(16'h0017);
            acc(1'b1, 1'b1, ~d);
            check({12'h000, fields}, {12'h000, mf});
            check(map, 16'h0017);
            acc(1'b0, 1'b0, 16'h0000);
            check(rdata, {mf, 12'h000});
            acc(1'b0, 1'b0, 16'h0000);
            check(rdata, 16'h0000);
            check(map, 16'h0019);
            check({8'h00, dead}, 16'(dt[i]));
            repeat (8) begin
                @(negedge clk);
                r = rnd();
                {scope, pa, pb, mst} = r[3:0];
                #1;
                check({14'h0000, inh_a}, {14'h0000, mf[1] | pa | mst, mf[1] & scope});
                check({14'h0000, inh_b}, {14'h0000, mf[0] | pb | mst, mf[0] & scope});
            end
            run_timer(0, lim[i]);
            run_timer(lim[i], lim[i]);
            run_timer(lim[i] + 1, lim[i]);
            run_timer(int'(r[3:0]) + 1, lim[i]);
        end
        test_done();
    end
endmodule
